// ==== common/qsh_pkg.sv ====
// Constants for the four-channel serial host port decoder.
package qsh_pkg;
	localparam int          ADDR_W          = 10;
	localparam int          DATA_W          = 8;
	localparam int          CHANNELS        = 4;
	// Base of the relocatable window for each bank switch position.
	localparam logic [9:0]  BANK_ON_BASE    = 10'h2A0;
	localparam logic [9:0]  BANK_OFF_BASE   = 10'h1A0;
	// Legacy ranges used by channels one and two in compatible mode.
	localparam logic [9:0]  FIRST_LEGACY    = 10'h3F8;
	localparam logic [9:0]  SECOND_LEGACY   = 10'h2F8;
	// Field positions inside a host address.
	localparam int          WIN_LSB         = 5;
	localparam int          RANGE_LSB       = 3;
	localparam logic [4:0]  VECTOR_OFFSET   = 5'h1F;
	localparam logic [1:0]  COMPAT_FIRST_IX = 2'h2;
	// Vector bits above the channel bits read as ones.
	localparam logic [3:0]  VECTOR_UPPER    = 4'hF;
	localparam logic [3:0]  SEL_IDLE_N      = 4'hF;
	localparam logic        GLOBAL_EN_RST   = 1'h0;
	// Crystal and reference clock figures in Hz, and the divide ratio between them.
	localparam int          XTAL_HZ         = 3686400;
	localparam int          REF_HZ          = 1843200;
	localparam int          REF_DIVIDE      = 2;
endpackage

// ==== common/ref_clock_if.sv ====
// Interface that carries the crystal level to the halver and the reference clock back.
interface ref_clock_if;
	logic xtal;
	logic ref_clk;
	modport divider (input xtal, output ref_clk);
	modport user    (output xtal, input ref_clk);
endinterface

// ==== rtl/ref_clock_halver.sv ====
// Divide-by-two of the sampled crystal oscillator level.
module ref_clock_halver (
	input  wire logic          clk,
	input  wire logic          rst,
	ref_clock_if.divider       rc
);
	logic xtal_prev;
	logic ref_q;
	logic next_xtal_prev;
	logic next_ref_q;

	// Toggle once on every rising crystal edge, halving its rate.
	always_comb begin
		next_xtal_prev = rc.xtal;
		next_ref_q     = ref_q;
		if (rc.xtal && !xtal_prev) begin
			next_ref_q = !ref_q;
		end
	end

	// Register the halver state.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xtal_prev <= 1'h0;
			ref_q     <= 1'h0;
		end else begin
			xtal_prev <= next_xtal_prev;
			ref_q     <= next_ref_q;
		end
	end

	assign rc.ref_clk = ref_q;

	// A rising crystal edge flips the reference clock on the next edge.
	AST_REF_HALVES: assert property (@(posedge clk) disable iff (rst)
		(rc.xtal && !xtal_prev) |=> (ref_q != $past(ref_q)))
		else $error("Reference clock did not toggle on crystal edge.");
	// Without a crystal edge the reference clock holds.
	AST_REF_HOLDS: assert property (@(posedge clk) disable iff (rst)
		!(rc.xtal && !xtal_prev) |=> $stable(ref_q))
		else $error("Reference clock moved without crystal edge.");
endmodule

// ==== rtl/quad_serial_host_decode.sv ====
// Host I/O decoder for four serial elements with a combined interrupt vector.
module quad_serial_host_decode #(
	parameter int NUM_CHANNELS = qsh_pkg::CHANNELS
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic [9:0]  HOST_ADDR,
	input  wire logic [7:0]  HOST_DATA_IN,
	input  wire logic        HOST_IOR_N,
	input  wire logic        HOST_IOW_N,
	input  wire logic        HOST_AEN,
	input  wire logic        MODE_SELECT_SWITCH,
	input  wire logic        ADDR_BANK_SWITCH,
	input  wire logic [3:0]  CHAN_IRQ,
	input  wire logic        XTAL_OSC,
	output logic      [3:0]  CHIP_SEL_N,
	output logic             VECTOR_RD_N,
	output logic      [7:0]  VECTOR_DATA,
	output logic             XCVR_EN_N,
	output logic             XCVR_DIR,
	output logic             GLOBAL_IRQ_EN,
	output logic             SERIAL_REF_CLK
);
	if (NUM_CHANNELS != qsh_pkg::CHANNELS) begin : g_check
		$error("Decoder serves exactly four serial elements.");
	end
	// The halver only divides by two, so the clock figures must agree with it.
	if (qsh_pkg::REF_DIVIDE != 2
	    || qsh_pkg::XTAL_HZ / qsh_pkg::REF_DIVIDE != qsh_pkg::REF_HZ) begin : g_ref_check
		$error("Reference clock figures do not halve the crystal.");
	end

	logic        cycle_valid;
	logic        is_read;
	logic [9:0]  win_base;
	logic        in_window;
	logic [1:0]  range_ix;
	logic        at_vector;
	logic [3:0]  hit;
	logic [3:0]  next_chip_sel_n;
	logic        next_vector_rd_n;
	logic [7:0]  next_vector_data;
	logic        next_xcvr_en_n;
	logic        next_xcvr_dir;
	logic        next_global_irq_en;

	ref_clock_if rc ();

	// The halver shares the core clock and samples the crystal as a level.
	ref_clock_halver u_halver (
		.clk (CORE_CLK),
		.rst (RESET),
		.rc  (rc.divider)
	);
	assign rc.xtal = XTAL_OSC;
	assign SERIAL_REF_CLK = rc.ref_clk; // Driven by the halver flip-flop.

	// Address decode: window by bank switch, legacy ranges by mode switch.
	always_comb begin
		cycle_valid = !HOST_AEN && (!HOST_IOR_N || !HOST_IOW_N);
		is_read     = !HOST_IOR_N;
		win_base    = ADDR_BANK_SWITCH ? qsh_pkg::BANK_ON_BASE
		                               : qsh_pkg::BANK_OFF_BASE;
		in_window   = HOST_ADDR[9:qsh_pkg::WIN_LSB] == win_base[9:qsh_pkg::WIN_LSB];
		range_ix    = HOST_ADDR[qsh_pkg::WIN_LSB-1:qsh_pkg::RANGE_LSB];
		at_vector   = in_window
		              && HOST_ADDR[qsh_pkg::WIN_LSB-1:0] == qsh_pkg::VECTOR_OFFSET;
		hit         = 4'h0;
		if (in_window) begin
			hit[range_ix] = 1'h1; // Enhanced: the window serves all four.
		end
		if (MODE_SELECT_SWITCH) begin
			// Compatible: relocatable window only serves channels three and four.
			hit[1:0] = 2'h0;
			if (HOST_ADDR[9:qsh_pkg::RANGE_LSB] == qsh_pkg::FIRST_LEGACY[9:qsh_pkg::RANGE_LSB]) begin
				hit[0] = 1'h1;
			end
			if (HOST_ADDR[9:qsh_pkg::RANGE_LSB] == qsh_pkg::SECOND_LEGACY[9:qsh_pkg::RANGE_LSB]) begin
				hit[1] = 1'h1;
			end
		end
		// The vector offset never reaches channel four's element.
		if (at_vector) begin
			hit[3] = 1'h0;
		end
	end

	// Next values of the strobes, transceiver control and vector latch.
	always_comb begin
		next_chip_sel_n    = qsh_pkg::SEL_IDLE_N;
		next_vector_rd_n   = 1'h1;
		next_global_irq_en = GLOBAL_IRQ_EN;
		if (cycle_valid) begin
			next_chip_sel_n  = ~hit;
			next_vector_rd_n = !(at_vector && is_read);
			if (at_vector && !HOST_IOW_N) begin
				next_global_irq_en = HOST_DATA_IN[0];
			end
		end
		next_xcvr_en_n   = (&next_chip_sel_n) && next_vector_rd_n;
		next_xcvr_dir    = cycle_valid && is_read; // High drives toward the host.
		next_vector_data = {qsh_pkg::VECTOR_UPPER, ~CHAN_IRQ};
	end

	// Register every output.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			CHIP_SEL_N    <= qsh_pkg::SEL_IDLE_N;
			VECTOR_RD_N   <= 1'h1;
			VECTOR_DATA   <= 8'hFF;
			XCVR_EN_N     <= 1'h1;
			XCVR_DIR      <= 1'h0;
			GLOBAL_IRQ_EN <= qsh_pkg::GLOBAL_EN_RST;
		end else begin
			CHIP_SEL_N    <= next_chip_sel_n;
			VECTOR_RD_N   <= next_vector_rd_n;
			VECTOR_DATA   <= next_vector_data;
			XCVR_EN_N     <= next_xcvr_en_n;
			XCVR_DIR      <= next_xcvr_dir;
			GLOBAL_IRQ_EN <= next_global_irq_en;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	// At most one element is selected at a time.
	AST_ONE_SELECT: assert property ($onehot0(~CHIP_SEL_N))
		else $error("More than one element selected.");
	// Without a valid cycle no element or vector strobe follows.
	AST_IDLE_NO_SELECT: assert property (!cycle_valid |=> (&CHIP_SEL_N) && VECTOR_RD_N)
		else $error("Strobe asserted without a valid host cycle.");
	// A vector read strobes the vector and turns the transceiver toward the host.
	AST_VECTOR_STROBE: assert property (
		(cycle_valid && is_read && at_vector) |=> !VECTOR_RD_N && !XCVR_EN_N && XCVR_DIR)
		else $error("Vector read did not strobe vector and transceiver.");
	// Compatible mode maps the first legacy range to channel one.
	AST_COMPAT_FIRST: assert property (
		(cycle_valid && MODE_SELECT_SWITCH && HOST_ADDR == qsh_pkg::FIRST_LEGACY)
		|=> CHIP_SEL_N == 4'hE)
		else $error("First legacy range did not select channel one.");
	// Enhanced mode ignores the legacy ranges.
	AST_ENH_NO_LEGACY: assert property (
		(cycle_valid && !MODE_SELECT_SWITCH && HOST_ADDR == qsh_pkg::SECOND_LEGACY)
		|=> &CHIP_SEL_N)
		else $error("Legacy range answered in enhanced mode.");
	// Bank off puts channel three at the low window in compatible mode.
	AST_BANK_OFF_CH3: assert property (
		(cycle_valid && MODE_SELECT_SWITCH && !ADDR_BANK_SWITCH && HOST_ADDR == 10'h1B0)
		|=> CHIP_SEL_N == 4'hB)
		else $error("Bank switch did not move channel three.");
	// The vector offset never selects channel four.
	AST_VECTOR_NOT_SCRATCH: assert property ((cycle_valid && at_vector) |=> CHIP_SEL_N[3])
		else $error("Vector address reached channel four element.");
	// Vector bits are the inverted requests of the previous cycle.
	AST_VECTOR_BITS: assert property (##1 VECTOR_DATA == {4'hF, ~$past(CHAN_IRQ)})
		else $error("Vector bits do not mirror channel requests.");

	// Compatible mode maps the second legacy range to channel two.
	AST_COMPAT_SECOND: assert property (
		(cycle_valid && MODE_SELECT_SWITCH
		&& HOST_ADDR[9:qsh_pkg::RANGE_LSB] == qsh_pkg::SECOND_LEGACY[9:qsh_pkg::RANGE_LSB])
		|=> CHIP_SEL_N == 4'hD)
		else $error("Second legacy range did not select channel two.");
	// Compatible mode leaves the low half of the window unmapped.
	AST_COMPAT_LOW_FREE: assert property (
		(cycle_valid && MODE_SELECT_SWITCH && in_window && !HOST_ADDR[qsh_pkg::WIN_LSB-1])
		|=> &CHIP_SEL_N)
		else $error("Low window half answered in compatible mode.");

	// Enhanced mode places channel one at the start of the window.
	AST_ENH_CH1: assert property (
		(cycle_valid && !MODE_SELECT_SWITCH && in_window && range_ix == 2'h0)
		|=> CHIP_SEL_N == 4'hE)
		else $error("Enhanced window did not select channel one.");
	// Enhanced mode places channel two in the second range of the window.
	AST_ENH_CH2: assert property (
		(cycle_valid && !MODE_SELECT_SWITCH && in_window && range_ix == 2'h1)
		|=> CHIP_SEL_N == 4'hD)
		else $error("Enhanced window did not select channel two.");
	// Enhanced mode places channel three in the third range of the window.
	AST_ENH_CH3: assert property (
		(cycle_valid && !MODE_SELECT_SWITCH && in_window && range_ix == 2'h2)
		|=> CHIP_SEL_N == 4'hB)
		else $error("Enhanced window did not select channel three.");
	// Enhanced mode places channel four in the last range, short of the vector.
	AST_ENH_CH4: assert property (
		(cycle_valid && !MODE_SELECT_SWITCH && in_window && range_ix == 2'h3 && !at_vector)
		|=> CHIP_SEL_N == 4'h7)
		else $error("Enhanced window did not select channel four.");

	// Bank on puts channel three of compatible mode at the high window.
	AST_BANK_ON_CH3: assert property (
		(cycle_valid && MODE_SELECT_SWITCH && ADDR_BANK_SWITCH && HOST_ADDR == 10'h2B0)
		|=> CHIP_SEL_N == 4'hB)
		else $error("Bank on did not place channel three.");
	// Bank on puts channel four at the high window in either mode.
	AST_BANK_ON_CH4: assert property (
		(cycle_valid && ADDR_BANK_SWITCH && HOST_ADDR == 10'h2B8)
		|=> CHIP_SEL_N == 4'h7)
		else $error("Bank on did not place channel four.");
	// Bank off puts channel one of enhanced mode at the low window.
	AST_BANK_OFF_ENH_CH1: assert property (
		(cycle_valid && !MODE_SELECT_SWITCH && !ADDR_BANK_SWITCH && HOST_ADDR == 10'h1A0)
		|=> CHIP_SEL_N == 4'hE)
		else $error("Bank off did not place channel one.");

	// A cycle with the address enable high is ignored entirely.
	AST_AEN_IGNORED: assert property (
		HOST_AEN |=> (&CHIP_SEL_N) && VECTOR_RD_N && XCVR_EN_N)
		else $error("Cycle with address enable high was decoded.");
	// Any valid read turns the transceiver toward the host.
	AST_READ_DIR: assert property (
		(cycle_valid && is_read) |=> XCVR_DIR)
		else $error("Read did not turn the transceiver toward the host.");
	// A write keeps the transceiver toward the board and never strobes the vector.
	AST_WRITE_NO_STROBE: assert property (
		(cycle_valid && !is_read) |=> !XCVR_DIR && VECTOR_RD_N)
		else $error("Write turned the transceiver or strobed the vector.");
	// Any selected element opens the transceiver.
	AST_SELECT_OPENS_XCVR: assert property (
		(cycle_valid && hit != 4'h0) |=> !XCVR_EN_N)
		else $error("Selected element left the transceiver shut.");
	// An unmapped cycle keeps the transceiver shut.
	AST_UNMAPPED_XCVR_SHUT: assert property (
		(cycle_valid && hit == 4'h0 && !(at_vector && is_read)) |=> XCVR_EN_N)
		else $error("Unmapped cycle opened the transceiver.");

	// Only the vector offset strobes the vector onto the bus.
	AST_VECTOR_ONLY_OFFSET: assert property (
		(cycle_valid && is_read && !at_vector) |=> VECTOR_RD_N)
		else $error("Vector strobed away from its offset.");
	// A write to the vector offset loads the global enable from data bit zero.
	AST_ENABLE_WRITE: assert property (
		(cycle_valid && at_vector && !HOST_IOW_N) |=> GLOBAL_IRQ_EN == $past(HOST_DATA_IN[0]))
		else $error("Vector write did not load the global enable.");
	// Without a vector write the global enable holds.
	AST_ENABLE_HOLDS: assert property (
		!(cycle_valid && at_vector && !HOST_IOW_N) |=> $stable(GLOBAL_IRQ_EN))
		else $error("Global enable moved without a vector write.");
endmodule

// ==== tb/host_io_model.sv ====
// Host processor I/O bus model that issues read and write cycles.
module host_io_model (
	output logic [9:0] addr,
	output logic [7:0] data,
	output logic       ior_n,
	output logic       iow_n,
	output logic       aen
);
	timeunit 1ns;
	timeprecision 1ps;
	// The bus starts idle with both strobes high.
	initial begin
		{addr, data, ior_n, iow_n, aen} = {10'h000, 8'h00, 3'h6};
	end
	// Drives one bus state; a released bus shows the inverse of its last value.
	task automatic put(input logic [9:0] a, input logic [7:0] d, input logic r, input logic w,
		input logic e);
		if (r | w) begin
			addr = a;
			data = d;
		end else begin
			addr = ~addr;
			data = ~data;
		end
		{ior_n, iow_n, aen} = {~r, ~w, e};
	endtask
endmodule

// ==== tb/quad_serial_host_decode_bench.sv ====
// Self-checking bench for the four-channel host decoder.
module quad_serial_host_decode_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk, reset, mode, bank, xtal, xtal_run, ior_n, iow_n, aen;
	logic [3:0] irq, sel_n, e_sel;
	logic [9:0] addr, a;
	logic [7:0] hdata, vdata, e_vec;
	logic       vrd_n, en_n, dir, gie, ref_clk, e_gie;
	logic [2:0] e_ctl;
	int         fails, cmp_count, cycles, rises, toggles, c, o;
	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	host_io_model u_host_io_model (.addr(addr), .data(hdata), .ior_n(ior_n), .iow_n(iow_n),
		.aen(aen));
	quad_serial_host_decode u_quad_serial_host_decode (.CORE_CLK(core_clk), .RESET(reset),
		.HOST_ADDR(addr), .HOST_DATA_IN(hdata), .HOST_IOR_N(ior_n), .HOST_IOW_N(iow_n),
		.HOST_AEN(aen), .MODE_SELECT_SWITCH(mode), .ADDR_BANK_SWITCH(bank), .CHAN_IRQ(irq),
		.XTAL_OSC(xtal), .CHIP_SEL_N(sel_n), .VECTOR_RD_N(vrd_n), .VECTOR_DATA(vdata),
		.XCVR_EN_N(en_n), .XCVR_DIR(dir), .GLOBAL_IRQ_EN(gie), .SERIAL_REF_CLK(ref_clk));
	// Crystal stand-in near 3.6 MHz and the cycle limit that cuts a hang short.
	always @(negedge core_clk) begin
		cycles++;
		if (xtal_run && cycles % 7 == 0) xtal <= ~xtal;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	// Counts crystal rises and reference clock edges out of reset for the halving check.
	always @(posedge xtal) rises++;
	always @(ref_clk) begin
		if (!reset) toggles++;
	end
	// Compares one value and counts the comparison.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Checks the previous cycle, then drives the next one and predicts its decode.
	task automatic step(input logic [9:0] a, input logic [7:0] d, input logic r, input logic w,
		input logic e);
		logic [9:0] base;
		@(negedge core_clk);
		check({4'h0, sel_n}, {4'h0, e_sel});
		check({5'h00, vrd_n, en_n, dir}, {5'h00, e_ctl});
		check(vdata, e_vec);
		check({7'h00, gie}, {7'h00, e_gie});
		u_host_io_model.put(a, d, r, w, e);
		irq = 4'($urandom);
		base = bank ? 10'h2A0 : 10'h1A0;
		e_sel = 4'hF;
		e_ctl = 3'h6;
		e_vec = {4'hF, ~irq};
		if (!e && (r | w)) begin
			e_ctl[0] = r;
			if (mode && a[9:3] == 7'h7F) e_sel[0] = 1'b0;
			if (mode && a[9:3] == 7'h5F) e_sel[1] = 1'b0;
			if (a[9:5] == base[9:5]) begin
				if (a[4:0] == 5'h1F) begin
					e_ctl[2] = ~r;
					if (w) e_gie = d[0];
				end else if (!mode || a[4]) e_sel[a[4:3]] = 1'b0;
			end
			e_ctl[1] = (e_sel == 4'hF) && e_ctl[2];
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Reset, then random back-to-back host cycles under every switch setting.
	initial begin
		void'($urandom(32'h57BC92A8));
		{reset, mode, bank, xtal, xtal_run, irq} = {5'h10, 4'h0};
		{e_sel, e_ctl, e_vec, e_gie} = {4'hF, 3'h6, 8'hFF, 1'h0};
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		xtal_run = 1'b1;
		for (int k = 0; k < 4; k++) begin
			step(10'h000, 8'h00, 1'b0, 1'b0, 1'b0);
			{mode, bank} = 2'(k);
			repeat (60) begin
				c = $urandom % 8;
				o = $urandom % 4;
				a = (c == 4) ? 10'h3F8 : (c == 5) ? 10'h2F8 : (bank ? 10'h2A0 : 10'h1A0) + 10'(c * 8);
				a = a + 10'($urandom % 8);
				if (c == 6) a = bank ? 10'h2BF : 10'h1BF;
				if (c == 7) a = 10'($urandom);
				step(a, 8'($urandom), o == 0 || o == 2, o == 1, o == 2);
			end
		end
		step(10'h000, 8'h00, 1'b0, 1'b0, 1'b0);
		xtal_run = 1'b0;
		repeat (4) @(negedge core_clk);
		check(8'(toggles), 8'(rises));
		close_out();
	end
endmodule
